// file: verification/pipeline_model.sv
/*
 * far side model: reset pins and the pipeline that raises requests.
 * assumes the bench calls its tasks and that it shares the core clock.
 */
module pipeline_model (
    // clock
    input  wire logic        clk,
    // reset pins, active low
    output logic             power_on_reset_n,
    output logic             manual_reset_input_n,
    // pipeline requests
    output logic             exc_req,
    output logic             exc_user_break,
    output logic [31:0]      exc_offset,
    output logic             int_req,
    output logic [3:0]       int_level,
    output logic [31:0]      int_offset
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------------------------------
    // pins idle high, requests idle low
    // ----------------------------------------------------------------
    initial begin
        {power_on_reset_n, manual_reset_input_n} = 2'h3;
        {exc_req, exc_user_break, int_req} = 3'h0;
        {exc_offset, int_offset, int_level} = 68'h0;
    end

    // pins are levels, changed just after an edge
    task automatic set_pins(input logic p, input logic m);
        @(posedge clk);
        power_on_reset_n     <= p;
        manual_reset_input_n <= m;
    endtask

    // one-cycle request; returns at the edge that takes it
    task automatic request(input logic e, input logic ub,
                           input logic [31:0] eo, input logic i,
                           input logic [3:0] lvl, input logic [31:0] io);
        @(posedge clk);
        exc_req        <= e;
        exc_user_break <= ub;
        exc_offset     <= eo;
        int_req        <= i;
        int_level      <= lvl;
        int_offset     <= io;
        @(posedge clk);
        exc_req <= 1'h0;
        int_req <= 1'h0;
    endtask
endmodule

// file: verification/testbench.sv
/*
 * self-checking bench for the reset and exception entry unit.
 * assumes the far side comes from pipeline_model; no random stimulus.
 */
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic                      clk = 1'h0;
    logic                      rst = 1'h1;
    logic [7:0]                addr = 8'h00;
    logic [31:0]               wdata = 32'h0;
    logic                      wr = 1'h0;
    logic                      rd = 1'h0;
    logic [31:0]               rdata, rv;
    logic                      por_n, man_n, er, eub, ir, core_reset;
    logic                      module_reset, seen, mr;
    logic [31:0]               eoff, ioff;
    logic [3:0]                ilvl;
    reset_entry_pkg::branch_t  branch, got;
    int                        errors = 0;
    int                        n_tests = 0;

    // 20 MHz core clock
    always #25 clk = ~clk;

    pipeline_model i_pipe (.clk(clk), .power_on_reset_n(por_n),
        .manual_reset_input_n(man_n), .exc_req(er), .exc_user_break(eub),
        .exc_offset(eoff), .int_req(ir), .int_level(ilvl),
        .int_offset(ioff));

    cpu_reset_exception_entry i_dut (.clk(clk), .rst(rst),
        .power_on_reset_n(por_n), .manual_reset_input_n(man_n),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .exc_req(er), .exc_user_break(eub), .exc_offset(eoff),
        .int_req(ir), .int_level(ilvl), .int_offset(ioff),
        .branch(branch), .core_reset(core_reset),
        .module_reset(module_reset));

    // ----------------------------------------------------------------
    // verdict, the single exit of the run
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // register port: one-cycle strobes, read data the cycle after
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'h1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'h1; addr <= a;
        @(posedge clk);
        rd <= 1'h0;
        #1 d = rdata;
    endtask

    // bounded wait for core_reset to reach a level
    task automatic wait_core(input logic lvl);
        for (int i = 0; i < 12; i++) begin
            @(posedge clk);
            #1 if (core_reset === lvl) return;
        end
        errors++;
        $display("[FAIL] core_reset wait timed out");
        summarize();
    endtask

    // look for one branch pulse over a short window
    task automatic wait_branch();
        seen = 1'h0;
        for (int i = 0; i < 4 && !seen; i++) begin
            #1 if (branch.valid === 1'h1) begin
                seen = 1'h1; got = branch; mr = module_reset;
            end
            if (!seen) @(posedge clk);
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        wait_core(1'h0);
        wait_branch();
        `CHK("reset branch", 1'h1, seen)
        `CHK("rst target", reset_entry_pkg::reset_vector, got.target)
        `CHK("reset cause", reset_entry_pkg::cause_reset, got.cause)
        reg_rd(reset_entry_pkg::off_status, rv);
        `CHK("status init", reset_entry_pkg::status_init, rv)
        reg_rd(reset_entry_pkg::off_base, rv);
        `CHK("base init", reset_entry_pkg::base_init, rv)
        // reserved and read-only bits must not stick; block bit cleared
        reg_wr(reset_entry_pkg::off_base, 32'h8000_0000);
        reg_wr(reset_entry_pkg::off_status, 32'h8fff_7f3f);
        reg_rd(reset_entry_pkg::off_status, rv);
        `CHK("status masked", 32'h0000_0030, rv)
        i_pipe.request(1'h1, 1'h0, 32'h100, 1'h0, 4'h0, 32'h0);
        wait_branch();
        `CHK("exc taken", 1'h1, seen)
        `CHK("exc target", 32'h8000_0100, got.target)
        `CHK("exc cause", reset_entry_pkg::cause_exception, got.cause)
        reg_rd(reset_entry_pkg::off_status, rv);
        `CHK("status entry", 32'h7000_0030, rv)
        // interrupt at the mask level is refused, one above is taken
        reg_wr(reset_entry_pkg::off_status, 32'h0000_0030);
        i_pipe.request(1'h0, 1'h0, 32'h0, 1'h1, 4'h3, 32'h600);
        wait_branch();
        `CHK("int at mask", 1'h0, seen)
        i_pipe.request(1'h0, 1'h0, 32'h0, 1'h1, 4'h4, 32'h600);
        wait_branch();
        `CHK("int taken", 1'h1, seen)
        `CHK("int target", 32'h8000_0600, got.target)
        `CHK("int cause", reset_entry_pkg::cause_interrupt, got.cause)
        // block bit now set: an interrupt above the mask is refused
        i_pipe.request(1'h0, 1'h0, 32'h0, 1'h1, 4'hf, 32'h600);
        wait_branch();
        `CHK("int blocked", 1'h0, seen)
        // block bit still set: user break ignored, other forces reset
        i_pipe.request(1'h1, 1'h1, 32'h100, 1'h0, 4'h0, 32'h0);
        wait_branch();
        `CHK("user break", 1'h0, seen)
        i_pipe.request(1'h1, 1'h0, 32'h100, 1'h0, 4'h0, 32'h0);
        wait_branch();
        `CHK("blocked seen", 1'h1, seen)
        `CHK("blk target", reset_entry_pkg::reset_vector, got.target)
        `CHK("blk cause", reset_entry_pkg::cause_blocked, got.cause)
        `CHK("module reset", 1'h1, mr)
        reg_rd(reset_entry_pkg::off_base, rv);
        `CHK("base blocked", reset_entry_pkg::base_init, rv)
        reg_rd(reset_entry_pkg::off_status, rv);
        `CHK("status blocked", reset_entry_pkg::status_init, rv)
        reg_rd(8'h3c, rv);
        `CHK("unmapped read", 32'h0, rv)
        // pin resets: k=0 power-on, k=1 manual
        for (int k = 0; k < 2; k++) begin
            reg_wr(reset_entry_pkg::off_base, 32'h1234_5670);
            reg_rd(reset_entry_pkg::off_base, rv);
            `CHK("base written", 32'h1234_5670, rv)
            i_pipe.set_pins(k[0], ~k[0]);
            wait_core(1'h1);
            reg_rd(reset_entry_pkg::off_event, rv);
            `CHK("reset state", 2'(k + 1), rv[3:2])
            i_pipe.set_pins(1'h1, 1'h1);
            wait_core(1'h0);
            wait_branch();
            `CHK("pin target", reset_entry_pkg::reset_vector, got.target)
            reg_rd(reset_entry_pkg::off_base, rv);
            `CHK("pin base", reset_entry_pkg::base_init, rv)
            reg_rd(reset_entry_pkg::off_status, rv);
            `CHK("pin status", reset_entry_pkg::status_init, rv)
        end
        summarize();
    end
endmodule

// file: verilog/cpu_reset_exception_entry.sv
/*
 * reset and exception entry: reset pin filtering, status and vector
 * base registers, vector selection and exception blocking.
 * assumes reset pins are asynchronous and active low, and that the
 * pipeline presents one request per cycle and takes branch on valid.
 */
// Strobed register access and the register offsets are this design's own decisions.
// Summary of operation
// - reset sets mode, bank, block bits, clears fpu disable, mask ones
// - every reset branches to a fixed, unwritable reset vector
// - exception and interrupt target is vector base plus event offset
// - block bit clear: exceptions are accepted, interrupts only above the mask level
// - block bit set: non user break exception forces manual reset
// - reset initialisation loads vector base with zero
// - power-on pin low, manual pin high enters power-on reset
module cpu_reset_exception_entry (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           rst,
    // reset pins, active low, asynchronous
    input  wire logic                           power_on_reset_n,
    input  wire logic                           manual_reset_input_n,
    // register port
    input  wire logic [7:0]                     addr,
    input  wire logic [31:0]                    wdata,
    input  wire logic                           wr,
    input  wire logic                           rd,
    output logic      [31:0]                    rdata,
    // pipeline requests
    input  wire logic                           exc_req,
    input  wire logic                           exc_user_break,
    input  wire logic [31:0]                    exc_offset,
    input  wire logic                           int_req,
    input  wire logic [3:0]                     int_level,
    input  wire logic [31:0]                    int_offset,
    // pipeline and module controls
    output reset_entry_pkg::branch_t            branch,
    output logic                                core_reset,
    output logic                                module_reset
);

    // ------------------------------------------------------------------
    // pin filtering
    // ------------------------------------------------------------------
    logic [2:0] por_sync;
    logic [2:0] mres_sync;
    logic       por_f;
    logic       mres_f;

    // three stages; a change counts once the last two agree
    always_ff @(posedge clk) begin
        if (rst) begin
            por_sync  <= 3'h7;
            mres_sync <= 3'h7;
            por_f     <= 1'b1;
            mres_f    <= 1'b1;
        end else begin
            por_sync  <= {por_sync[1:0], power_on_reset_n};
            mres_sync <= {mres_sync[1:0], manual_reset_input_n};
            if (por_sync[1] == por_sync[2]) begin
                por_f <= por_sync[2];
            end
            if (mres_sync[1] == mres_sync[2]) begin
                mres_f <= mres_sync[2];
            end
        end
    end

    // ------------------------------------------------------------------
    // reset state machine
    // ------------------------------------------------------------------
    reset_entry_pkg::reset_state_t state;
    reset_entry_pkg::reset_state_t next_state;
    logic                          in_reset;
    logic                          release_reset;

    // both pins low counts as power-on, the stronger reset
    always_comb begin
        next_state = state;
        if (!por_f) begin
            next_state = reset_entry_pkg::st_power_on;
        end else if (!mres_f) begin
            next_state = reset_entry_pkg::st_manual;
        end else begin
            next_state = reset_entry_pkg::st_run;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= reset_entry_pkg::st_power_on;
        end else begin
            state <= next_state;
        end
    end

    assign in_reset      = (state != reset_entry_pkg::st_run);
    assign release_reset = in_reset && (next_state == reset_entry_pkg::st_run);
    assign core_reset    = in_reset;

    // ------------------------------------------------------------------
    // request decisions
    // ------------------------------------------------------------------
    logic [31:0] cpu_status_register;
    logic [31:0] vector_base_register;
    logic        exception_block_bit;
    logic        exc_take;
    logic        exc_blocked;
    logic        int_take;
    logic        reinit;

    assign exception_block_bit =
        cpu_status_register[reset_entry_pkg::block_pos];
    // requests during reset are dropped: the pipeline is held anyway
    assign exc_take    = !in_reset && exc_req && !exception_block_bit;
    assign exc_blocked = !in_reset && exc_req && exception_block_bit
                         && !exc_user_break;
    // a general exception outranks a simultaneous interrupt
    assign int_take    = !in_reset && int_req && !exc_req
                         && !exception_block_bit
                         && (int_level > cpu_status_register[
                             reset_entry_pkg::mask_hi:
                             reset_entry_pkg::mask_lo]);
    assign reinit      = in_reset || exc_blocked;

    // ------------------------------------------------------------------
    // status and vector base registers
    // ------------------------------------------------------------------
    // hardware initialisation wins over a software write in that cycle
    always_ff @(posedge clk) begin
        if (rst || reinit) begin
            cpu_status_register <= reset_entry_pkg::status_init;
        end else if (exc_take || int_take) begin
            cpu_status_register <= cpu_status_register
                                   | reset_entry_pkg::entry_set_bits;
        end else if (wr && addr == reset_entry_pkg::off_status) begin
            cpu_status_register <= wdata
                                   & reset_entry_pkg::status_writable;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || reinit) begin
            vector_base_register <= reset_entry_pkg::base_init;
        end else if (wr && addr == reset_entry_pkg::off_base) begin
            vector_base_register <= wdata;
        end
    end

    // ------------------------------------------------------------------
    // branch generation
    // ------------------------------------------------------------------
    logic [1:0] last_cause;

    // reset vector is a constant, no write path reaches it
    always_ff @(posedge clk) begin
        if (rst) begin
            branch <= '0;
        end else if (release_reset || exc_blocked) begin
            branch.valid  <= 1'b1;
            branch.cause  <= release_reset ? reset_entry_pkg::cause_reset
                                           : reset_entry_pkg::cause_blocked;
            branch.target <= reset_entry_pkg::reset_vector;
        end else if (exc_take) begin
            branch.valid  <= 1'b1;
            branch.cause  <= reset_entry_pkg::cause_exception;
            branch.target <= vector_base_register + exc_offset;
        end else if (int_take) begin
            branch.valid  <= 1'b1;
            branch.cause  <= reset_entry_pkg::cause_interrupt;
            branch.target <= vector_base_register + int_offset;
        end else begin
            branch.valid  <= 1'b0;
        end
    end

    // one-cycle manual reset to the other modules on a blocked exception
    always_ff @(posedge clk) begin
        if (rst) begin
            module_reset <= 1'b0;
        end else begin
            module_reset <= exc_blocked;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            last_cause <= reset_entry_pkg::cause_reset;
        end else if (release_reset || exc_blocked) begin
            last_cause <= release_reset ? reset_entry_pkg::cause_reset
                                        : reset_entry_pkg::cause_blocked;
        end else if (exc_take) begin
            last_cause <= reset_entry_pkg::cause_exception;
        end else if (int_take) begin
            last_cause <= reset_entry_pkg::cause_interrupt;
        end
    end

    // ------------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------------
    // data only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (rst || !rd) begin
            rdata <= '0;
        end else begin
            unique case (addr)
                reset_entry_pkg::off_status: rdata <= cpu_status_register;
                reset_entry_pkg::off_base:   rdata <= vector_base_register;
                reset_entry_pkg::off_event:  rdata <= {28'h0000000,
                                                       state, last_cause};
                default:                     rdata <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_status_init;
        @(posedge clk) disable iff (rst)
        in_reset |=> cpu_status_register == reset_entry_pkg::status_init;
    endproperty
    a_status_init: assert property (p_status_init)
        else $error("status not initialised during reset");

    property p_reset_vector;
        @(posedge clk) disable iff (rst)
        release_reset |=> branch.valid
            && branch.target == reset_entry_pkg::reset_vector;
    endproperty
    a_reset_vector: assert property (p_reset_vector)
        else $error("reset release did not branch to reset vector");

    property p_exc_target;
        @(posedge clk) disable iff (rst)
        exc_take |=> branch.valid && branch.target ==
            $past(vector_base_register) + $past(exc_offset);
    endproperty
    a_exc_target: assert property (p_exc_target)
        else $error("exception target is not base plus offset");

    property p_int_blocked;
        @(posedge clk) disable iff (rst)
        (int_req && !exc_req && exception_block_bit && !in_reset)
            |=> !branch.valid;
    endproperty
    a_int_blocked: assert property (p_int_blocked)
        else $error("interrupt taken while blocked");

    property p_blocked_reset;
        @(posedge clk) disable iff (rst)
        exc_blocked |=> module_reset && branch.cause ==
            reset_entry_pkg::cause_blocked
            ##1 (!module_reset || $past(exc_blocked));
    endproperty
    a_blocked_reset: assert property (p_blocked_reset)
        else $error("blocked exception did not force manual reset");

    property p_base_init;
        @(posedge clk) disable iff (rst)
        reinit |=> vector_base_register == reset_entry_pkg::base_init;
    endproperty
    a_base_init: assert property (p_base_init)
        else $error("vector base not cleared by initialisation");

    property p_power_on;
        @(posedge clk) disable iff (rst)
        (!por_f && mres_f) |=> state == reset_entry_pkg::st_power_on;
    endproperty
    a_power_on: assert property (p_power_on)
        else $error("power-on reset state not entered");

    property p_manual;
        @(posedge clk) disable iff (rst)
        (por_f && !mres_f) |=> state == reset_entry_pkg::st_manual
            && core_reset;
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual reset state not entered");

endmodule

// file: verilog/reset_entry_pkg.sv
/*
 * constants, types and the status register layout for the reset and
 * exception entry unit.
 * assumes one 20 MHz core clock and a plain register port.
 */
package reset_entry_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] off_status = 8'h00;
    localparam logic [7:0] off_base   = 8'h04;
    localparam logic [7:0] off_event  = 8'h08;

    // ------------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------------
    localparam int mode_pos    = 30;
    localparam int bank_pos    = 29;
    localparam int block_pos   = 28;
    localparam int fpu_off_pos = 15;
    localparam int mask_lo     = 4;
    localparam int mask_hi     = 7;
    localparam logic [31:0] status_writable = 32'h7000_80f0;
    localparam logic [31:0] status_init     = 32'h7000_00f0;
    localparam logic [31:0] entry_set_bits  = 32'h7000_0000;

    // ------------------------------------------------------------------
    // vectors
    // ------------------------------------------------------------------
    localparam logic [31:0] reset_vector = 32'ha000_0000;
    localparam logic [31:0] base_init    = 32'h0000_0000;

    // ------------------------------------------------------------------
    // entry causes and the branch carrier
    // ------------------------------------------------------------------
    localparam logic [1:0] cause_reset     = 2'h0;
    localparam logic [1:0] cause_exception = 2'h1;
    localparam logic [1:0] cause_interrupt = 2'h2;
    localparam logic [1:0] cause_blocked   = 2'h3;

    typedef struct packed {
        logic        valid;
        logic [1:0]  cause;
        logic [31:0] target;
    } branch_t;

    typedef enum logic [1:0] {
        st_run,
        st_power_on,
        st_manual
    } reset_state_t;

endpackage
